// File: design/linear_array_defs.svh
// What this block does
// - Start raised, taken on a clock rise
// - Controller drops start before next clock rise
// - Start rise freezes samples and begins integrator reset
// - One token bit per pixel sequences the readout
// - One stored pixel drives the output per clock
// - Integrators reset first 18 clocks, free on 19th
// - Clock 129 shifts token out, output released
// - Controller always issues the 129th clock
// - Next start waits one transfer interval after 129
// - Output released whenever no readout runs
// - Charge transfer interval is 20 microseconds
//
// Purpose: Shared constants of the linear array readout pair.
// Assumes: One system clock of 25 MHz on both ends.
// Notes: The transfer gap count derives from its time in ns.
`ifndef LINEAR_ARRAY_DEFS_SVH
`define LINEAR_ARRAY_DEFS_SVH
`define NUM_PIXELS 128
`define PIX_WIDTH 8
`define RESET_CLKS 18
`define INTEG_START_CLK 19
`define END_CLK 129
`define CLK_PERIOD_NS 40
`define XFER_INTERVAL_NS 20000
`define XFER_INTERVAL_CYCLES ((`XFER_INTERVAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_DIV 8
`define MIN_HALF_DIV 8
`define FIFO_DEPTH 4
`define SYNC_STAGES 3
`endif

// File: design/linear_array_pkg.sv
// Purpose: Types of the linear array readout pair.
// Assumes: Constants come from linear_array_defs.svh.
// Notes: Controller states only; the sensor has no state machine.
package linear_array_pkg;
  typedef enum logic [1:0] {
    CTRL_IDLE = 2'b00,
    CTRL_ARM = 2'b01,
    CTRL_RUN = 2'b10,
    CTRL_GAP = 2'b11
  } ctrl_state_t;
endpackage

// File: design/sensor_link_if.sv
// Purpose: Pins between the sensor end and the controller end.
// Assumes: Both ends run on the same system clock.
// Notes: The analog output is a sample word plus its drive enable.
`timescale 1ns/1ns
`default_nettype none
interface sensor_link_if #(parameter int PIX_W = 8);
  logic start;              // Start pulse, controller drives
  logic sclk;               // Pixel clock, controller drives
  logic [PIX_W-1:0] pix;    // Analog pixel output value
  logic pix_oe;             // High while the sensor drives the output
  modport sensor (input start, input sclk, output pix, output pix_oe);
  modport ctrl (output start, output sclk, input pix, input pix_oe);
endinterface
`default_nettype wire

// File: design/sensor_end.sv
// Purpose: Sensor end: token shift register, hold, integrator reset, output.
// Assumes: Link pins come from another domain and are synchronised.
// Notes: Pixel clock and start are sampled, never used as clocks.
`timescale 1ns/1ns
`default_nettype none
`include "linear_array_defs.svh"
module sensor_end #(
  parameter int PIX_W = `PIX_WIDTH,
  parameter int NUM_PIX = `NUM_PIXELS
) (
  input wire logic clk_i,                        // System clock
  input wire logic reset_i,                      // Async reset, high
  input wire logic [NUM_PIX*PIX_W-1:0] pixels_i, // Live integrator levels
  output logic hold_o,                           // One-cycle sample freeze
  output logic integ_reset_o,                    // Integrators held in reset
  output logic busy_o,                           // Output phase running
  sensor_link_if.sensor link                     // Link to the controller
);
  localparam int CW = 8;
  localparam int IW = $clog2(NUM_PIX);
  localparam int SI_BIT = 0;
  localparam int CK_BIT = 1;

  // The count ends at a fixed clock, so the pixel count must match it
  if (NUM_PIX != `END_CLK - 1 || NUM_PIX + 1 > 255 || PIX_W < 1)
  begin : g_bad_param
    $error("sensor_end: unsupported parameters");
  end

  logic [1:0] pin_w;
  logic [`SYNC_STAGES-1:0] sync_r [2];
  logic [`SYNC_STAGES-1:0] sync_nxt [2];
  logic lvl_r [2];
  logic lvl_nxt [2];

  assign pin_w[SI_BIT] = link.start;
  assign pin_w[CK_BIT] = link.sclk;

  // Three-stage synchronisers; stage 0 feeds stage 1 only
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      always_comb
      begin
        sync_nxt[g] = {sync_r[g][`SYNC_STAGES-2:0], pin_w[g]};
        lvl_nxt[g] = lvl_r[g];
        if (sync_r[g][1] == sync_r[g][2])
          lvl_nxt[g] = sync_r[g][2]; // Change counts once stages agree
      end
      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          sync_r[g] <= '0;
          lvl_r[g] <= 1'b0;
        end
        else
        begin
          sync_r[g] <= sync_nxt[g];
          lvl_r[g] <= lvl_nxt[g];
        end
      end
    end
  endgenerate

  logic clk_rise_w;
  logic start_rise_w;
  assign clk_rise_w = lvl_nxt[CK_BIT] & ~lvl_r[CK_BIT];
  assign start_rise_w = lvl_nxt[SI_BIT] & ~lvl_r[SI_BIT];

  // Stored samples, frozen by hold
  logic [PIX_W-1:0] mem_r [NUM_PIX];
  generate
    for (g = 0; g < NUM_PIX; g++)
    begin : g_mem
      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
          mem_r[g] <= '0;
        else if (start_rise_w)
          mem_r[g] <= pixels_i[g*PIX_W +: PIX_W];
      end
    end
  endgenerate

  logic [NUM_PIX-1:0] sr_r;
  logic [NUM_PIX-1:0] sr_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic ireset_r;
  logic ireset_nxt;
  logic hold_r;
  logic hold_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [PIX_W-1:0] pix_r;
  logic [PIX_W-1:0] pix_nxt;
  logic [IW-1:0] idx_w;

  assign idx_w = IW'(cnt_nxt - CW'(1));

  // Readout sequencing on each accepted pixel clock rise
  always_comb
  begin
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    ireset_nxt = ireset_r;
    hold_nxt = start_rise_w;
    pix_nxt = pix_r;
    if (clk_rise_w)
    begin
      // Token enters on the clock rise while start is high
      sr_nxt = {sr_r[NUM_PIX-2:0], lvl_nxt[SI_BIT]};
      if (lvl_nxt[SI_BIT])
        cnt_nxt = CW'(1);
      else if (cnt_r == CW'(`END_CLK - 1))
        cnt_nxt = '0;
      else if (cnt_r != '0)
        cnt_nxt = cnt_r + CW'(1);
      if (cnt_nxt == CW'(`INTEG_START_CLK))
        ireset_nxt = 1'b0;
    end
    // A fresh start outranks the end of an old reset period
    if (start_rise_w)
      ireset_nxt = 1'b1;
    // Held through the first 18 clocks of a readout
    if (cnt_nxt != '0 && cnt_nxt <= CW'(`RESET_CLKS))
      ireset_nxt = 1'b1;
    if (cnt_nxt != '0)
      pix_nxt = mem_r[idx_w];
    // Driven only while a token sits in the register
    oe_nxt = (|sr_nxt) && (cnt_nxt != '0);
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sr_r <= '0;
      cnt_r <= '0;
      ireset_r <= 1'b0;
      hold_r <= 1'b0;
      oe_r <= 1'b0;
      pix_r <= '0;
    end
    else
    begin
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      ireset_r <= ireset_nxt;
      hold_r <= hold_nxt;
      oe_r <= oe_nxt;
      pix_r <= pix_nxt;
    end
  end

  // Output pins and status straight from flops
  assign link.pix = pix_r;
  assign link.pix_oe = oe_r;
  assign hold_o = hold_r;
  assign integ_reset_o = ireset_r;
  assign busy_o = oe_r;
endmodule
`default_nettype wire

// File: design/ctrl_end.sv
// Purpose: Controller end: start pulse, pixel clock, sample capture.
// Assumes: Sensor output settles within half a pixel clock period.
// Notes: A full FIFO stalls the pixel clock with it low-going held high.
`timescale 1ns/1ns
`default_nettype none
`include "linear_array_defs.svh"
module pixel_fifo #(
  parameter int WIDTH = `PIX_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_i,               // System clock
  input wire logic reset_i,             // Async reset, high
  input wire logic [WIDTH-1:0] in_data_i, // Write word
  input wire logic in_valid_i,          // Write request
  output logic in_ready_o,              // Room for a word
  output logic [WIDTH-1:0] out_data_o,  // Head word
  output logic out_valid_o,             // Head word present
  input wire logic out_ready_i          // Reader takes head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_depth
    $error("pixel_fifo: depth must be a power of two");
  end
  // Word store and pointers; one spare count bit tells full from empty
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic wr_w;
  logic rd_w;
  assign wr_w = in_valid_i & in_ready_o;
  assign rd_w = out_valid_o & out_ready_i;

  // Pointer and fill bookkeeping
  always_comb
  begin
    wp_nxt = wr_w ? wp_r + AW'(1) : wp_r;
    rp_nxt = rd_w ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr_w) - (AW+1)'(rd_w);
  end
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (wr_w)
      mem_r[wp_r] <= in_data_i;
  end
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
endmodule

module ctrl_end #(
  parameter int PIX_W = `PIX_WIDTH,
  parameter int HALF_DIV = `HALF_DIV,
  parameter int XFER_CYC = `XFER_INTERVAL_CYCLES,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_i,              // System clock
  input wire logic reset_i,            // Async reset, high
  input wire logic start_i,            // Request one readout
  output logic busy_o,                 // Readout or gap running
  output logic [PIX_W-1:0] pix_data_o, // Captured pixel
  output logic pix_valid_o,            // Captured pixel present
  input wire logic pix_ready_i,        // User takes pixel
  sensor_link_if.ctrl link             // Link to the sensor
);
  localparam int CW = 8;
  localparam int DW = 16;
  // Sensor needs four cycles to show a pixel after a rise
  if (HALF_DIV < `MIN_HALF_DIV || HALF_DIV > 65535 || XFER_CYC < 1 || XFER_CYC > 65535)
  begin : g_bad_param
    $error("ctrl_end: unsupported parameters");
  end

  linear_array_pkg::ctrl_state_t st_r;
  linear_array_pkg::ctrl_state_t st_nxt;
  logic [DW-1:0] div_r;
  logic [DW-1:0] div_nxt;
  logic [CW-1:0] edge_r;
  logic [CW-1:0] edge_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic si_r;
  logic si_nxt;
  logic busy_r;
  logic busy_nxt;
  // Push request, buffer room and divider tick
  logic push_w;
  logic in_ready_w;
  logic tick_w;

  assign tick_w = (div_r == '0);

  // Pixel clock divider and readout sequence
  always_comb
  begin
    st_nxt = st_r;
    div_nxt = (div_r == '0) ? DW'(HALF_DIV - 1) : div_r - DW'(1);
    edge_nxt = edge_r;
    sclk_nxt = sclk_r;
    si_nxt = si_r;
    push_w = 1'b0;
    case (st_r)
      linear_array_pkg::CTRL_IDLE:
      begin
        div_nxt = DW'(HALF_DIV - 1);
        if (start_i)
        begin
          si_nxt = 1'b1;
          st_nxt = linear_array_pkg::CTRL_ARM;
        end
      end
      linear_array_pkg::CTRL_ARM:
      begin
        if (tick_w)
        begin
          sclk_nxt = 1'b1;
          edge_nxt = CW'(1);
          st_nxt = linear_array_pkg::CTRL_RUN;
        end
      end
      linear_array_pkg::CTRL_RUN:
      begin
        if (tick_w && !sclk_r)
        begin
          sclk_nxt = 1'b1;
          edge_nxt = edge_r + CW'(1);
        end
        else if (tick_w && sclk_r)
        begin
          si_nxt = 1'b0;
          // Keep counts 1 to 128 only; stall on a full FIFO
          if (edge_r < CW'(`END_CLK))
          begin
            push_w = 1'b1;
            if (!in_ready_w)
              div_nxt = div_r;
            else
              sclk_nxt = 1'b0;
          end
          else
          begin
            sclk_nxt = 1'b0;
            div_nxt = DW'(XFER_CYC - 1);
            st_nxt = linear_array_pkg::CTRL_GAP;
          end
        end
      end
      linear_array_pkg::CTRL_GAP:
      begin
        if (tick_w)
          st_nxt = linear_array_pkg::CTRL_IDLE;
      end
      default:
        st_nxt = linear_array_pkg::CTRL_IDLE;
    endcase
    busy_nxt = (st_nxt != linear_array_pkg::CTRL_IDLE);
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r <= linear_array_pkg::CTRL_IDLE;
      div_r <= '0;
      edge_r <= '0;
      sclk_r <= 1'b0;
      si_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      edge_r <= edge_nxt;
      sclk_r <= sclk_nxt;
      si_r <= si_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Samples on counts 1 to 128; zero is stored while the sensor does not drive its output
  pixel_fifo #(.WIDTH(PIX_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_data_i(link.pix_oe ? link.pix : '0),
    .in_valid_i(push_w),
    .in_ready_o(in_ready_w),
    .out_data_o(pix_data_o),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i)
  );

  assign link.start = si_r;
  assign link.sclk = sclk_r;
  assign busy_o = busy_r;
endmodule
`default_nettype wire

// File: verif/link_monitor.sv
// Purpose: Checker on the link between the two readout ends.
// Assumes: Signals are taken plainly from the link interface.
// Notes: Counts pixel clock rises itself; gap counter saturates.
`timescale 1ns/1ns
`default_nettype none
module link_monitor #(
  parameter int PIX_W = 8,
  parameter int XFER_CYC = 500
) (
  input wire logic clk_i,             // System clock
  input wire logic reset_i,           // Async reset, high
  input wire logic start_i,           // Start pulse
  input wire logic sclk_i,            // Pixel clock
  input wire logic [PIX_W-1:0] pix_i, // Pixel word
  input wire logic pix_oe_i           // Sensor drives output
);
  logic sclk_r;
  logic [7:0] rise_cnt_r;
  logic [7:0] since_r;
  logic [15:0] gap_r;
  logic rise;
  assign rise = sclk_i & ~sclk_r;
  // since_r and gap_r saturate, so a first start after reset passes the gap test
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sclk_r <= 1'b0;
      rise_cnt_r <= 8'h00;
      since_r <= 8'hff;
      gap_r <= 16'hffff;
    end
    else
    begin
      sclk_r <= sclk_i;
      if (rise)
      begin
        rise_cnt_r <= start_i ? 8'h01 : rise_cnt_r + 8'h01;
        since_r <= 8'h00;
      end
      else if (since_r != 8'hff)
        since_r <= since_r + 8'h01;
      if (rise && rise_cnt_r == 8'h80)
        gap_r <= 16'h0000;
      else if (gap_r != 16'hffff)
        gap_r <= gap_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_START_ONE_TOKEN: assert property (rise && start_i |-> ##[1:20] !start_i)
    else $error("start held past one pixel clock");
  AST_START_IN_IDLE: assert property ($rose(start_i) |-> !pix_oe_i && !sclk_i)
    else $error("start raised outside idle");
  AST_OE_FOLLOWS_TOKEN: assert property (rise && start_i |-> ##[2:7] pix_oe_i)
    else $error("output not driven after token");
  AST_PIX_STEADY: assert property (
    $changed(pix_i) && pix_oe_i && $past(pix_oe_i) |-> since_r < 8'h08)
    else $error("pixel word moved between clocks");
  AST_OE_ENDS_129: assert property ($fell(pix_oe_i) |-> rise_cnt_r == 8'h81)
    else $error("output released at wrong clock");
  AST_OE_IDLE_LOW: assert property (
    since_r > 8'h07 && (rise_cnt_r == 8'h00 || rise_cnt_r == 8'h81) |-> !pix_oe_i)
    else $error("output driven outside readout");
  AST_LAST_CLOCK: assert property (
    rise && rise_cnt_r == 8'h7f |-> ##[15:200] (rise && rise_cnt_r == 8'h80))
    else $error("final clock missing");
  AST_GAP_KEPT: assert property ($rose(start_i) |-> gap_r >= XFER_CYC)
    else $error("start too soon after last clock");
  cover property (rise && rise_cnt_r == 8'h80);
  cover property ($rose(start_i));
  cover property ($fell(pix_oe_i));
  // Pixel clock held high by a full buffer
  cover property (sclk_i && since_r == 8'h20);
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the readout pair.
// Assumes: Short charge transfer gap for a quick run.
// Notes: Pixel k of a line carries base plus k.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int PW = 8;
  localparam int NP = 128;
  localparam int TQ = 40;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  logic pix_ready_i = 1'b0;
  logic [7:0] base_r = 8'h00;
  logic [NP*PW-1:0] pixels_i;
  logic hold_o;
  logic integ_reset_o;
  logic s_busy;
  logic c_busy;
  logic pix_valid_o;
  logic [PW-1:0] pix_data_o;
  logic sclk_r = 1'b0;
  logic start_r = 1'b0;
  logic irst_r = 1'b0;
  logic [7:0] rise_cnt_r = 8'h00;
  logic [7:0] starts_r = 8'h00;
  logic [7:0] hold_at_r = 8'hff;
  logic [7:0] irst_end_r = 8'hff;
  int fail_count = 0;
  int checked = 0;
  sensor_link_if #(.PIX_W(PW)) link ();
  sensor_end #(.PIX_W(PW), .NUM_PIX(NP)) i_sensor_end (.clk_i(clk_i), .reset_i(reset_i),
    .pixels_i(pixels_i), .hold_o(hold_o), .integ_reset_o(integ_reset_o), .busy_o(s_busy),
    .link(link));
  ctrl_end #(.PIX_W(PW), .XFER_CYC(TQ)) i_ctrl_end (.clk_i(clk_i), .reset_i(reset_i),
    .start_i(start_i), .busy_o(c_busy), .pix_data_o(pix_data_o), .pix_valid_o(pix_valid_o),
    .pix_ready_i(pix_ready_i), .link(link));
  link_monitor #(.PIX_W(PW), .XFER_CYC(TQ)) i_link_monitor (.clk_i(clk_i), .reset_i(reset_i),
    .start_i(link.start), .sclk_i(link.sclk), .pix_i(link.pix), .pix_oe_i(link.pix_oe));
  always #20 clk_i = ~clk_i;
  // Live levels; they move after each freeze to prove the hold
  always_comb
  begin
    for (int k = 0; k < NP; k++)
      pixels_i[k*PW +: PW] = base_r + 8'(k);
  end
  // Own view of the wire: clock rises since the token, hold and reset moments
  always @(posedge clk_i)
  begin
    sclk_r <= link.sclk;
    start_r <= link.start;
    irst_r <= integ_reset_o;
    // Moments are cleared per line so a missing event shows up
    if (link.start && !start_r)
    begin
      rise_cnt_r <= 8'h00;
      starts_r <= starts_r + 8'h01;
      hold_at_r <= 8'hff;
      irst_end_r <= 8'hff;
    end
    else if (link.sclk && !sclk_r)
      rise_cnt_r <= rise_cnt_r + 8'h01;
    if (hold_o)
      hold_at_r <= rise_cnt_r;
    if (irst_r && !integ_reset_o)
      irst_end_r <= rise_cnt_r;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Request a line and wait for the freeze, then disturb the live levels
  task automatic launch(input logic [7:0] base);
    int n;
    n = 0;
    @(posedge clk_i);
    base_r <= base;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    while (hold_o !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    check("hold seen", hold_o, 1'b1);
    @(negedge clk_i);
    check("irst at hold", integ_reset_o, 1'b1);
    @(posedge clk_i);
    base_r <= ~base;
  endtask
  // Take all pixels in order, then judge the end of the line
  task automatic drain(input logic [7:0] base);
    int n;
    @(posedge clk_i);
    pix_ready_i <= 1'b1;
    for (int k = 0; k < NP; k++)
    begin
      n = 0;
      @(negedge clk_i);
      while (pix_valid_o !== 1'b1 && n < 400)
      begin
        @(negedge clk_i);
        n++;
      end
      check("pixel valid", pix_valid_o, 1'b1);
      check("pixel", pix_data_o, 8'(base + 8'(k)));
      @(posedge clk_i);
    end
    n = 0;
    while (c_busy !== 1'b0 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    check("ctrl idle", c_busy, 1'b0);
    check("rises", rise_cnt_r, 8'h81);
    check("hold at", hold_at_r, 8'h00);
    check("irst end", irst_end_r, 8'h13);
    check("oe idle", link.pix_oe, 1'b0);
    check("sensor busy", s_busy, 1'b0);
  endtask
  task automatic plain_line;
    launch(8'h10);
    drain(8'h10);
  endtask
  // User stalls: buffer fills, clock waits, a start request mid-line is refused
  task automatic stalled_line;
    @(posedge clk_i);
    pix_ready_i <= 1'b0;
    launch(8'h80);
    repeat (150) @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(negedge clk_i);
    check("full valid", pix_valid_o, 1'b1);
    check("clock held", link.sclk, 1'b1);
    drain(8'h80);
    check("starts", starts_r, 8'h02);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    plain_line();
    stalled_line();
    complete_run();
  end
  // Hang guard, well above two lines with gaps
  initial
  begin
    repeat (12000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
